// ---- hw/i2cep_port.sv ----
// EEPROM I2C master port: software side, link engine and synchronisers
//
// Summary of operation
// - Pin route value 2 puts bus clock on fault pin 0, data on pin 1.
// - Master and I2C mode enables must both be set before launching.
// - Clock-low timeout detector exists and a disable bit switches it off.
// - Bus clock is 100 kHz by default, about 1 MHz with fast-plus.
// - Fast-mode bit selects a 400 kHz bus clock when fast-plus is clear.
// - Unmasked end-of-message raises the shared request regardless of controller.
// - End-of-message request shares one line with the comparator request.
// - Writing the transfer control word launches a transaction with its fields.
// - Transmit word is plain 32 bits; later writes send next four bytes.
// - Transmit word bytes leave least significant byte first.
// - After a word is sent with bytes remaining, set data-request.
// - Reading the status word clears its flags.
// - After the byte count is written out, generate a stop.
// - Final transfer sets end-of-message instead of data-request.
// - Slave refusal sets NACK, before end-of-message of that message.
// - Read with count one sends read address then receives one byte.
// - Command and extended read: address, two bytes, restart, address, reads.
// - Without command enable, send only the read address.
// - Data-ready is set when up to four received bytes are available.
// - Reading the receive word starts clocking in the next four bytes.
// - Last read byte is answered with NACK, then a stop.
// - Byte count field holds up to 255.

// ------------------------------------------------------------------
// Two-flop level synchroniser
// ------------------------------------------------------------------
module i2cep_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule : i2cep_sync

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module i2cep_port #(
  parameter int unsigned TIMEOUT_CYCLES = i2cep_pkg::TMO_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        linkClock,
  input  wire logic [2:0]  pinRoute,
  input  wire logic        masterEnable,
  input  wire logic        i2cModeEnable,
  input  wire logic        clockLowTimeoutDisable,
  input  wire logic        fastMode,
  input  wire logic        fastModePlus,
  input  wire logic        eomMask,
  input  wire logic        comparatorRequest,
  output logic             sharedComparatorRequest,
  input  wire logic        ctrlWrite,
  input  wire logic [6:0]  slaveAddress,
  input  wire logic [7:0]  byteCount,
  input  wire logic        readNotWrite,
  input  wire logic        commandPhaseEnable,
  input  wire logic        twoByteCommandSelect,
  input  wire logic        txWrite,
  input  wire logic [31:0] txData,
  input  wire logic        rxRead,
  output logic      [31:0] rxData,
  input  wire logic        statusRead,
  output logic      [4:0]  status,
  input  wire logic        faultPin0In,
  output logic             faultPin0Out,
  output logic             faultPin0Oe,
  input  wire logic        faultPin1In,
  output logic             faultPin1Out,
  output logic             faultPin1Oe
);
  import i2cep_pkg::*;

  // ----------------------------------------------------------------
  // Software side (clock)
  // ----------------------------------------------------------------
  logic [6:0]  cSlave;
  logic [7:0]  cCount;
  logic        cRead;
  logic        cCmd;
  logic        cExt;
  logic [31:0] txHold;
  logic        tgStart;
  logic        tgTx;
  logic        tgRx;
  logic        routed;
  logic [4:0]  tgLinkQ;
  logic [4:0]  tgLinkPrev;
  logic [4:0]  evSys;
  logic [31:0] rxWord;
  logic        tgDreq;
  logic        tgEom;
  logic        tgNack;
  logic        tgDrdy;
  logic        tgTmo;

  // Launch only when both enables are set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cSlave  <= 7'h00;
      cCount  <= 8'h00;
      cRead   <= 1'b0;
      cCmd    <= 1'b0;
      cExt    <= 1'b0;
      tgStart <= 1'b0;
    end else if (ctrlWrite && masterEnable && i2cModeEnable) begin
      cSlave  <= slaveAddress;
      cCount  <= byteCount;
      cRead   <= readNotWrite;
      cCmd    <= commandPhaseEnable;
      cExt    <= twoByteCommandSelect;
      tgStart <= ~tgStart;
    end
  end

  // Transmit word and receive-read events
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txHold <= 32'h0000_0000;
      tgTx   <= 1'b0;
      tgRx   <= 1'b0;
      routed <= 1'b0;
    end else begin
      routed <= (pinRoute == ROUTE_I2C);
      if (txWrite) begin
        txHold <= txData;
        tgTx   <= ~tgTx;
      end
      if (rxRead) begin
        tgRx <= ~tgRx;
      end
    end
  end

  // Events from the link domain
  i2cep_sync #(.W(SB_W)) syncSys (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({tgTmo, tgDrdy, tgNack, tgEom, tgDreq}),
    .q      (tgLinkQ)
  );

  assign evSys = tgLinkQ ^ tgLinkPrev;

  // Sticky flags; a new event beats the read clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tgLinkPrev              <= '0;
      status                  <= '0;
      rxData                  <= 32'h0000_0000;
      sharedComparatorRequest <= 1'b0;
    end else begin
      tgLinkPrev <= tgLinkQ;
      status     <= evSys | (status & ~{SB_W{statusRead}});
      if (evSys[SB_DRDY]) begin
        rxData <= rxWord;
      end
      sharedComparatorRequest <= (status[SB_EOM] & ~eomMask) | comparatorRequest;
    end
  end

  // ----------------------------------------------------------------
  // Link side (linkClock)
  // ----------------------------------------------------------------
  i2cep_state_t state;
  i2cep_kind_t  kind;
  logic [8:0]   syncL;
  logic         startEv;
  logic         txEv;
  logic         rxEv;
  logic         prevStart;
  logic         prevTx;
  logic         prevRx;
  logic         txPend;
  logic         rxPend;
  logic [7:0]   qtrCnt;
  logic [7:0]   qtrReload;
  logic         tick;
  logic [1:0]   phase;
  logic [3:0]   bitIdx;
  logic [1:0]   lane;
  logic [1:0]   nextLane;
  logic [7:0]   remaining;
  logic [7:0]   txByte;
  logic [7:0]   rxByte;
  logic         ackHigh;
  logic         sclLow;
  logic         sdaLow;
  logic         extRead;
  logic [TMO_W-1:0] lowCnt;
  logic         timeoutHit;

  // Controls, levels and pins brought into the link domain
  i2cep_sync #(.W(9)) syncLink (
    .clock  (linkClock),
    .arst_n (arst_n),
    .d      ({tgStart, tgTx, tgRx, fastMode, fastModePlus,
              clockLowTimeoutDisable, routed, faultPin0In, faultPin1In}),
    .q      (syncL)
  );

  wire fmL     = syncL[5];
  wire fmpL    = syncL[4];
  wire tmoDisL = syncL[3];
  wire routedL = syncL[2];
  wire sclIn   = syncL[1];
  wire sdaIn   = syncL[0];

  assign startEv  = syncL[8] ^ prevStart;
  assign txEv     = syncL[7] ^ prevTx;
  assign rxEv     = syncL[6] ^ prevRx;
  assign extRead  = cRead & cCmd & cExt;
  assign nextLane = lane + 2'h1;
  assign tick     = (qtrCnt == 8'h00);
  assign qtrReload = fmpL ? QTR_FMP : (fmL ? QTR_FAST : QTR_STD);

  // Open-drain pins, driven only when routed
  assign faultPin0Out = 1'b0;
  assign faultPin1Out = 1'b0;
  assign faultPin0Oe  = routedL & sclLow;
  assign faultPin1Oe  = routedL & sdaLow;

  // Quarter bit timer
  always_ff @(posedge linkClock or negedge arst_n) begin
    if (!arst_n) begin
      qtrCnt <= 8'h00;
    end else begin
      qtrCnt <= tick ? qtrReload - 8'h01 : qtrCnt - 8'h01;
    end
  end

  // Clock-low timeout, skipped when disabled
  assign timeoutHit = (lowCnt == TMO_W'(TIMEOUT_CYCLES - 1)) && !tmoDisL
                      && (state != ST_IDLE);
  always_ff @(posedge linkClock or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt <= '0;
    end else if (sclIn) begin
      lowCnt <= '0;
    end else if (lowCnt != TMO_W'(TIMEOUT_CYCLES - 1)) begin
      lowCnt <= lowCnt + TMO_W'(1);
    end
  end

  // Software events waiting for the engine; launch clears stale ones
  always_ff @(posedge linkClock or negedge arst_n) begin
    if (!arst_n) begin
      prevStart <= 1'b0;
      prevTx    <= 1'b0;
      prevRx    <= 1'b0;
      txPend    <= 1'b0;
      rxPend    <= 1'b0;
    end else begin
      prevStart <= syncL[8];
      prevTx    <= syncL[7];
      prevRx    <= syncL[6];
      if (startEv && state == ST_IDLE) begin
        txPend <= 1'b0;
        rxPend <= 1'b0;
      end else begin
        txPend <= txEv | (txPend & (state != ST_WTX));
        rxPend <= rxEv | (rxPend & (state != ST_WRX));
      end
    end
  end

  // Transfer engine
  always_ff @(posedge linkClock or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_IDLE;
      kind      <= K_ADDRW;
      phase     <= PH_SETUP;
      bitIdx    <= 4'h0;
      lane      <= 2'h0;
      remaining <= 8'h00;
      txByte    <= 8'h00;
      rxByte    <= 8'h00;
      rxWord    <= 32'h0000_0000;
      ackHigh   <= 1'b0;
      sclLow    <= 1'b0;
      sdaLow    <= 1'b0;
      tgDreq    <= 1'b0;
      tgEom     <= 1'b0;
      tgNack    <= 1'b0;
      tgDrdy    <= 1'b0;
      tgTmo     <= 1'b0;
    end else if (timeoutHit) begin
      state  <= ST_IDLE;
      sclLow <= 1'b0;
      sdaLow <= 1'b0;
      tgTmo  <= ~tgTmo;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startEv) begin
            state     <= ST_START;
            phase     <= PH_SETUP;
            remaining <= cCount;
            kind      <= (cRead && !extRead) ? K_ADDRR : K_ADDRW;
          end
        end
        ST_WTX: begin
          if (txPend) begin
            state  <= ST_BIT;
            lane   <= 2'h0;
            txByte <= txHold[7:0];
          end
        end
        ST_WRX: begin
          if (rxPend) begin
            state <= ST_BIT;
            lane  <= 2'h0;
          end
        end
        ST_START: begin
          // Start or repeated start
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              PH_SETUP:  sdaLow <= 1'b0;
              PH_RISE:   sclLow <= 1'b0;
              PH_SAMPLE: sdaLow <= 1'b1;
              default: begin
                sclLow <= 1'b1;
                state  <= ST_BIT;
                bitIdx <= 4'h0;
                txByte <= {cSlave, kind == K_ADDRR};
              end
            endcase
          end
        end
        ST_BIT: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              PH_SETUP: begin
                if (bitIdx == ACK_BIT) begin
                  sdaLow <= (kind == K_RX) && (remaining != 8'h01);
                end else begin
                  sdaLow <= (kind != K_RX) && !txByte[7];
                end
              end
              PH_RISE: sclLow <= 1'b0;
              PH_SAMPLE: begin
                if (bitIdx == ACK_BIT) begin
                  ackHigh <= sdaIn;
                end else begin
                  rxByte <= {rxByte[6:0], sdaIn};
                end
              end
              default: begin
                sclLow <= 1'b1;
                if (bitIdx != ACK_BIT) begin
                  bitIdx <= bitIdx + 4'h1;
                  txByte <= {txByte[6:0], 1'b0};
                end else begin
                  bitIdx <= 4'h0;
                  if (kind != K_RX && ackHigh) begin
                    tgNack <= ~tgNack;
                    state  <= ST_STOP;
                  end else begin
                    case (kind)
                      K_ADDRW: begin
                        lane   <= 2'h0;
                        txByte <= txHold[7:0];
                        if (extRead) begin
                          kind <= K_CMD;
                        end else if (remaining == 8'h00) begin
                          state <= ST_STOP;
                        end else begin
                          kind <= K_TX;
                        end
                      end
                      K_CMD: begin
                        if (lane == CMD_LAST) begin
                          kind  <= K_ADDRR;
                          state <= ST_START;
                        end else begin
                          lane   <= nextLane;
                          txByte <= txHold[{nextLane, 3'h0} +: 8];
                        end
                      end
                      K_ADDRR: begin
                        lane <= 2'h0;
                        if (remaining == 8'h00) begin
                          state <= ST_STOP;
                        end else begin
                          kind <= K_RX;
                        end
                      end
                      K_TX: begin
                        remaining <= remaining - 8'h01;
                        lane      <= nextLane;
                        txByte    <= txHold[{nextLane, 3'h0} +: 8];
                        if (remaining == 8'h01) begin
                          state <= ST_STOP;
                        end else if (lane == LANE_LAST) begin
                          tgDreq <= ~tgDreq;
                          state  <= ST_WTX;
                        end
                      end
                      default: begin
                        remaining <= remaining - 8'h01;
                        lane      <= nextLane;
                        if (lane == 2'h0) begin
                          rxWord <= {24'h00_0000, rxByte};
                        end else begin
                          rxWord[{lane, 3'h0} +: 8] <= rxByte;
                        end
                        if (remaining == 8'h01) begin
                          tgDrdy <= ~tgDrdy;
                          state  <= ST_STOP;
                        end else if (lane == LANE_LAST) begin
                          tgDrdy <= ~tgDrdy;
                          state  <= ST_WRX;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              PH_SETUP: begin
                sclLow <= 1'b1;
                sdaLow <= 1'b1;
              end
              PH_RISE:   sclLow <= 1'b0;
              PH_SAMPLE: sdaLow <= 1'b0;
              default: begin
                state <= ST_IDLE;
                tgEom <= ~tgEom;
              end
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_route;
    @(posedge linkClock) disable iff (!arst_n)
    !routedL |-> !faultPin0Oe && !faultPin1Oe;
  endproperty
  a_route: assert property (p_route) else $error("pins driven while unrouted");

  property p_enable;
    @(posedge clock) disable iff (!arst_n)
    ctrlWrite && !(masterEnable && i2cModeEnable) |=> $stable(tgStart);
  endproperty
  a_enable: assert property (p_enable) else $error("launch while disabled");

  property p_noTmo;
    @(posedge linkClock) disable iff (!arst_n)
    tmoDisL ##1 tmoDisL |-> $stable(tgTmo);
  endproperty
  a_noTmo: assert property (p_noTmo) else $error("timeout while disabled");

  property p_speed;
    @(posedge linkClock) disable iff (!arst_n)
    tick && $stable(fmL) && $stable(fmpL) |=> qtrCnt == $past(qtrReload) - 8'h01;
  endproperty
  a_speed: assert property (p_speed) else $error("quarter bit reload wrong");

  property p_share;
    @(posedge clock) disable iff (!arst_n)
    status[SB_EOM] && !eomMask |=> sharedComparatorRequest;
  endproperty
  a_share: assert property (p_share) else $error("shared request missing");

  property p_clear;
    @(posedge clock) disable iff (!arst_n)
    statusRead && evSys == '0 |=> status == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");

  property p_dreq;
    @(posedge linkClock) disable iff (!arst_n)
    $changed(tgDreq) |-> state == ST_WTX && remaining != 8'h00;
  endproperty
  a_dreq: assert property (p_dreq) else $error("data request misplaced");

  property p_stop;
    @(posedge linkClock) disable iff (!arst_n)
    state == ST_STOP && tick && phase == PH_LAST && !timeoutHit
      |=> state == ST_IDLE && $changed(tgEom);
  endproperty
  a_stop: assert property (p_stop) else $error("stop without end of message");

  property p_nack;
    @(posedge linkClock) disable iff (!arst_n)
    $changed(tgNack) && tmoDisL |-> state == ST_STOP ##[1:1000] $changed(tgEom);
  endproperty
  a_nack: assert property (p_nack) else $error("nack not followed by eom");

  property p_lastNack;
    @(posedge linkClock) disable iff (!arst_n)
    state == ST_BIT && kind == K_RX && bitIdx == ACK_BIT
      && remaining == 8'h01 && phase == PH_RISE |-> !sdaLow;
  endproperty
  a_lastNack: assert property (p_lastNack) else $error("last byte acked");

  c_eom:  cover property (@(posedge clock) disable iff (!arst_n) evSys[SB_EOM]);
  c_nack: cover property (@(posedge clock) disable iff (!arst_n) evSys[SB_NACK]);
  c_wrx:  cover property (@(posedge linkClock) disable iff (!arst_n) state == ST_WRX);
  c_ext:  cover property (@(posedge linkClock) disable iff (!arst_n)
                          state == ST_START && kind == K_ADDRR && extRead);

endmodule : i2cep_port

// ---- hw/i2cep_pkg.sv ----
// Constants and types shared by the EEPROM I2C master port
package i2cep_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LINK_PERIOD_NS = 30;
  localparam int STD_PERIOD_NS  = 10000;
  localparam int FAST_PERIOD_NS = 2500;
  localparam int FMP_PERIOD_NS  = 1000;
  // Quarter bit times, rounded up so the bus never runs fast
  localparam logic [7:0] QTR_STD  =
    8'((STD_PERIOD_NS / 4 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] QTR_FAST =
    8'((FAST_PERIOD_NS / 4 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] QTR_FMP  =
    8'((FMP_PERIOD_NS / 4 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam int TMO_LIMIT_MS     = 25;
  localparam int TMO_CYCLES_DEF   = TMO_LIMIT_MS * 1000000 / LINK_PERIOD_NS;
  localparam int TMO_W            = 20;

  // ----------------------------------------------------------------
  // Fields and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] ROUTE_I2C = 3'h2;
  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [1:0] PH_SETUP  = 2'h0;
  localparam logic [1:0] PH_RISE   = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST   = 2'h3;
  localparam logic [1:0] LANE_LAST = 2'h3;
  localparam logic [1:0] CMD_LAST  = 2'h1;
  // Status word bit positions
  localparam int SB_DREQ = 0;
  localparam int SB_EOM  = 1;
  localparam int SB_NACK = 2;
  localparam int SB_DRDY = 3;
  localparam int SB_TMO  = 4;
  localparam int SB_W    = 5;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_STOP, ST_WTX, ST_WRX
  } i2cep_state_t;

  typedef enum logic [2:0] {
    K_ADDRW, K_CMD, K_ADDRR, K_TX, K_RX
  } i2cep_kind_t;

endpackage : i2cep_pkg

// ---- tb/i2cep_eeprom_model.sv ----
// Behavioural serial EEPROM slave for the port bench
module i2cep_eeprom_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic refuse,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  logic [7:0] rdByte;
  logic       rd = 1'b0;
  logic       sel = 1'b0;
  int         bi = 0;
  int         nb = 0;
  logic [7:0] got[$];
  initial sdaLow = 1'b0;
  // Start, restart or stop: new framing, line released
  always @(sda) begin
    if (scl === 1'b1) begin
      bi = 0;
      nb = 0;
      rd = 1'b0;
      sel = 1'b0;
      sdaLow = 1'b0;
    end
  end
  // Shift in; master high at read acknowledge stops sending
  always @(posedge scl) begin
    if (bi < 8)
      sh = {sh[6:0], sda};
    else if (rd && sda)
      sel = 1'b0;
    bi = (bi == 8) ? 0 : bi + 1;
    if (bi == 0)
      nb++;
  end
  // Acknowledge and read data change only while the clock is low
  always @(negedge scl) begin
    rdByte = 8'hA0 + 8'(nb);
    if (bi == 8) begin
      if (nb == 0) begin
        sel = (sh[7:1] == ADDR) && !refuse;
        rd  = sh[0];
      end else if (!rd && sel)
        got.push_back(sh);
      sdaLow = sel && !(rd && nb > 0);
    end else
      sdaLow = rd && sel && nb > 0 && !rdByte[7 - bi];
  end
endmodule : i2cep_eeprom_model

// ---- tb/i2cep_port_tb.sv ----
// Self-checking bench for the EEPROM I2C master port
module i2cep_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        linkClock = 1'b0;
  logic        arst_n = 1'b0;
  logic        masterEn = 1'b1;
  logic [2:0]  route = 3'h2;
  logic        tmoDis = 1'b1;
  logic        eomMask = 1'b0;
  logic        cmpReq = 1'b0;
  logic        ctrlWrite = 1'b0;
  logic [7:0]  byteCount = 8'h00;
  logic        rw = 1'b0;
  logic        cmd = 1'b0;
  logic        txWrite = 1'b0;
  logic [31:0] txData = 32'h0;
  logic        rxRead = 1'b0;
  logic        statusRead = 1'b0;
  logic        refuse = 1'b0;
  logic        shared;
  logic [31:0] rxData;
  logic [4:0]  status;
  logic [4:0]  st;
  logic        sclOe;
  logic        sdaOe;
  logic        sdaLow;
  wire         scl = ~sclOe;
  wire         sda = ~sdaOe & ~sdaLow;
  int          n_mismatch = 0;
  int          n_checks = 0;
  always #5 clock = ~clock;
  initial #7 forever #15 linkClock = ~linkClock;
  i2cep_port #(.TIMEOUT_CYCLES(2000)) i2cep_port_i (
    .clock(clock), .arst_n(arst_n), .linkClock(linkClock), .pinRoute(route),
    .masterEnable(masterEn), .i2cModeEnable(1'b1), .clockLowTimeoutDisable(tmoDis),
    .fastMode(1'b0), .fastModePlus(1'b1), .eomMask(eomMask), .comparatorRequest(cmpReq),
    .sharedComparatorRequest(shared), .ctrlWrite(ctrlWrite), .slaveAddress(7'h50),
    .byteCount(byteCount), .readNotWrite(rw), .commandPhaseEnable(cmd),
    .twoByteCommandSelect(cmd), .txWrite(txWrite), .txData(txData), .rxRead(rxRead),
    .rxData(rxData), .statusRead(statusRead), .status(status), .faultPin0In(scl),
    .faultPin0Out(), .faultPin0Oe(sclOe), .faultPin1In(sda), .faultPin1Out(),
    .faultPin1Oe(sdaOe));
  i2cep_eeprom_model eeprom_i (.scl(scl), .sda(sda), .refuse(refuse), .sdaLow(sdaLow));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // One clock, inputs change just after it
  task automatic step;
    @(posedge clock);
    #1;
  endtask : step
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (status[b] !== 1'b1 && n < 30000) begin
      step();
      n++;
    end
    check(32'(n < 30000), 32'h1);
  endtask : wait_flag
  // Read the status word, then expect it cleared
  task automatic take_status;
    st = status;
    statusRead = 1'b1;
    step();
    statusRead = 1'b0;
    step();
    check(32'(status), 32'h0);
  endtask : take_status
  task automatic pulse_tx(input logic [31:0] w);
    txData = w;
    txWrite = 1'b1;
    step();
    txWrite = 1'b0;
    step();
  endtask : pulse_tx
  task automatic launch(input logic r, input logic [7:0] cnt, input logic c);
    rw = r;
    byteCount = cnt;
    cmd = c;
    ctrlWrite = 1'b1;
    step();
    ctrlWrite = 1'b0;
  endtask : launch
  // Launch refused while master mode is off; comparator request passes
  task automatic test_disabled;
    masterEn = 1'b0;
    launch(1'b0, 8'h01, 1'b0);
    repeat (3000) step();
    check(32'({status, sclOe}), 32'h0);
    masterEn = 1'b1;
    cmpReq = 1'b1;
    repeat (3) step();
    check(32'(shared), 32'h1);
    cmpReq = 1'b0;
    // Unrouted pins stay released, so the address goes unanswered
    route = 3'h0;
    launch(1'b0, 8'h00, 1'b0);
    wait_flag(i2cep_pkg::SB_EOM);
    take_status();
    check(32'(st), 32'h06);
    route = 3'h2;
  endtask : test_disabled
  // Clock held low in a read wait: timeout fires only once enabled
  task automatic test_timeout;
    launch(1'b1, 8'h05, 1'b0);
    wait_flag(i2cep_pkg::SB_DRDY);
    take_status();
    repeat (8000) step();
    check(32'(status), 32'h0);
    tmoDis = 1'b0;
    wait_flag(i2cep_pkg::SB_TMO);
    take_status();
    check(32'(st & 5'h12), 32'h10);
    tmoDis = 1'b1;
  endtask : test_timeout
  // Six byte write across two transmit words
  task automatic test_write;
    pulse_tx(32'h44332211);
    launch(1'b0, 8'h06, 1'b0);
    wait_flag(i2cep_pkg::SB_DREQ);
    take_status();
    check(32'(st), 32'h01);
    pulse_tx(32'h00006655);
    wait_flag(i2cep_pkg::SB_EOM);
    repeat (3) step();
    check(32'(shared), 32'h1);
    take_status();
    check(32'(st), 32'h02);
    check(32'(eeprom_i.got.size()), 32'h6);
    for (int i = 0; i < eeprom_i.got.size(); i++)
      check(32'(eeprom_i.got[i]), 32'(17 * (i + 1)));
    eeprom_i.got.delete();
  endtask : test_write
  // Slave refuses its address
  task automatic test_refuse;
    refuse = 1'b1;
    launch(1'b1, 8'h01, 1'b0);
    wait_flag(i2cep_pkg::SB_NACK);
    check(32'(status[i2cep_pkg::SB_EOM]), 32'h0);
    wait_flag(i2cep_pkg::SB_EOM);
    take_status();
    check(32'(st), 32'h06);
    refuse = 1'b0;
  endtask : test_refuse
  // Read in groups of four, optionally after a two byte command
  task automatic test_read(input logic c, input logic [7:0] cnt);
    logic [31:0] exp;
    pulse_tx(32'h00003412);
    launch(1'b1, cnt, c);
    for (int g = 0; g * 4 < cnt; g++) begin
      wait_flag(i2cep_pkg::SB_DRDY);
      exp = 32'h0;
      for (int k = 0; k < 4; k++)
        if (g * 4 + k < cnt)
          exp[8 * k +: 8] = 8'hA1 + 8'(g * 4 + k);
      check(rxData, exp);
      take_status();
      rxRead = 1'b1;
      step();
      rxRead = 1'b0;
    end
    wait_flag(i2cep_pkg::SB_EOM);
    take_status();
    check(32'(st & 5'h06), 32'h02);
    check(32'(eeprom_i.got.size()), c ? 32'h2 : 32'h0);
    if (c)
      check({eeprom_i.got[0], eeprom_i.got[1]}, 16'h1234);
    eeprom_i.got.delete();
  endtask : test_read
  initial begin
    repeat (16) step();
    arst_n = 1'b1;
    repeat (2) step();
    test_disabled();
    test_write();
    test_refuse();
    test_read(1'b0, 8'h01);
    test_read(1'b0, 8'h05);
    test_read(1'b1, 8'h02);
    test_timeout();
    finish_test();
  end
  initial begin
    #900000;
    n_mismatch++;
    finish_test();
  end
endmodule : i2cep_port_tb
